// ### src/i2c_exp_device.sv
// Serial slave with four port registers driving eight two-way pins
`timescale 1ns/1ns
module i2c_exp_device #(
    parameter int WIDTH = i2c_exp_pkg::PORT_WIDTH
) (
    input wire logic clock,
    input wire logic resetn,
    i2c_link_if.device link,
    input wire logic [i2c_exp_pkg::STRAP_WIDTH-1:0] addr_strap_pins,
    input wire logic [WIDTH-1:0] port_pin_in,
    output logic [WIDTH-1:0] port_pin_out,
    output logic [WIDTH-1:0] port_pin_oe_n
);
    localparam int SW = i2c_exp_pkg::STRAP_WIDTH;
    localparam int NS = WIDTH + SW + 2;
    localparam int SCL_I = NS - 1;
    localparam int SDA_I = NS - 2;

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_addr = 3'h1,
        st_ack_addr = 3'h3,
        st_wr_byte = 3'h2,
        st_ack_wr = 3'h6,
        st_rd_byte = 3'h7,
        st_ack_rd = 3'h5
    } state_type;

    state_type state_q, state_d;
    logic [NS-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
    logic [7:0] shift_q, shift_d;
    logic [3:0] count_q, count_d;
    logic rw_q, rw_d;
    logic cmd_due_q, cmd_due_d;
    logic sda_out_q, sda_out_d;
    logic sda_oe_n_q, sda_oe_n_d;
    logic [7:0] ptr_q, ptr_d;
    logic [WIDTH-1:0] out_q, out_d, inv_q, inv_d, dir_q, dir_d;

    // Three-stage filter: a change is taken once stages two and three agree
    wire [NS-1:0] agree = ~(s2_q ^ s3_q);
    assign filt_d = (s2_q & agree) | (filt_q & ~agree);

    wire scl = filt_q[SCL_I];
    wire sda = filt_q[SDA_I];
    wire scl_prev = prev_q[SCL_I];
    wire sda_prev = prev_q[SDA_I];
    wire [SW-1:0] strap = filt_q[WIDTH +: SW];
    wire [WIDTH-1:0] pins = filt_q[WIDTH-1:0];
    wire scl_rise = scl & ~scl_prev;
    wire scl_fall = ~scl & scl_prev;
    wire start_seen = scl & scl_prev & sda_prev & ~sda;
    wire stop_seen = scl & scl_prev & ~sda_prev & sda;
    wire byte_done = count_q == i2c_exp_pkg::BITS_PER_BYTE;
    // Strap pins are compared live; the bench keeps them steady
    wire addr_match = shift_q[7:1] == {i2c_exp_pkg::ADDR_FIXED, strap};
    wire [1:0] sel = {ptr_q[i2c_exp_pkg::SEL_HI], ptr_q[i2c_exp_pkg::SEL_LO]};
    wire [WIDTH-1:0] in_view = pins ^ inv_q;
    wire [WIDTH-1:0] rd_value = (sel == i2c_exp_pkg::REG_INPUT) ? in_view :
                                (sel == i2c_exp_pkg::REG_OUTPUT) ? out_q :
                                (sel == i2c_exp_pkg::REG_INVERT) ? inv_q : dir_q;
    wire [7:0] rd_byte = 8'(rd_value);

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        count_d = count_q;
        rw_d = rw_q;
        cmd_due_d = cmd_due_q;
        sda_out_d = sda_out_q;
        sda_oe_n_d = sda_oe_n_q;
        ptr_d = ptr_q;
        out_d = out_q;
        inv_d = inv_q;
        dir_d = dir_q;
        if (start_seen) begin
            // Repeated start lands here too, from any state
            state_d = st_addr;
            count_d = 4'h0;
            sda_oe_n_d = 1'b1;
            sda_out_d = 1'b1;
        end else if (stop_seen) begin
            state_d = st_idle;
            sda_oe_n_d = 1'b1;
            sda_out_d = 1'b1;
        end else begin
            unique case (state_q)
                st_idle: begin
                    count_d = 4'h0;
                end
                st_addr, st_wr_byte: begin
                    if (scl_rise && !byte_done) begin
                        shift_d = {shift_q[6:0], sda};
                        count_d = count_q + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        count_d = 4'h0;
                        if (state_q == st_wr_byte || addr_match) begin
                            sda_oe_n_d = 1'b0;
                            sda_out_d = 1'b0;
                            state_d = (state_q == st_addr) ? st_ack_addr : st_ack_wr;
                            if (state_q == st_addr) begin
                                rw_d = shift_q[0];
                                cmd_due_d = shift_q[0] == i2c_exp_pkg::RW_WRITE;
                            end
                        end else begin
                            state_d = st_idle;
                        end
                    end
                end
                st_ack_addr: begin
                    if (scl_fall) begin
                        if (rw_q == i2c_exp_pkg::RW_READ) begin
                            sda_out_d = rd_byte[7];
                            sda_oe_n_d = rd_byte[7];
                            shift_d = {rd_byte[6:0], 1'b0};
                            count_d = 4'h0;
                            state_d = st_rd_byte;
                        end else begin
                            sda_oe_n_d = 1'b1;
                            sda_out_d = 1'b1;
                            state_d = st_wr_byte;
                        end
                    end
                end
                st_ack_wr: begin
                    if (scl_rise) begin
                        if (cmd_due_q) begin
                            ptr_d = shift_q;
                            cmd_due_d = 1'b0;
                        end else begin
                            // Pointer stays put between data bytes
                            unique case (sel)
                                i2c_exp_pkg::REG_INPUT: ;
                                i2c_exp_pkg::REG_OUTPUT: out_d = WIDTH'(shift_q);
                                i2c_exp_pkg::REG_INVERT: inv_d = WIDTH'(shift_q);
                                i2c_exp_pkg::REG_DIRECTION: dir_d = WIDTH'(shift_q);
                            endcase
                        end
                    end else if (scl_fall) begin
                        sda_oe_n_d = 1'b1;
                        sda_out_d = 1'b1;
                        state_d = st_wr_byte;
                    end
                end
                st_rd_byte: begin
                    if (scl_rise) begin
                        count_d = count_q + 4'h1;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            // Hand SDA to the master for its acknowledge
                            sda_oe_n_d = 1'b1;
                            sda_out_d = 1'b1;
                            state_d = st_ack_rd;
                        end else begin
                            sda_out_d = shift_q[7];
                            sda_oe_n_d = shift_q[7];
                            shift_d = {shift_q[6:0], 1'b0};
                        end
                    end
                end
                st_ack_rd: begin
                    if (scl_rise) begin
                        rw_d = ~sda; // Master ack low keeps the read going
                    end else if (scl_fall) begin
                        count_d = 4'h0;
                        if (rw_q) begin
                            sda_out_d = rd_byte[7];
                            sda_oe_n_d = rd_byte[7];
                            shift_d = {rd_byte[6:0], 1'b0};
                            state_d = st_rd_byte;
                        end else begin
                            state_d = st_idle;
                        end
                    end
                end
                default: begin
                    state_d = st_idle;
                    sda_oe_n_d = 1'b1;
                    sda_out_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            filt_q <= '1;
            prev_q <= '1;
        end else begin
            s1_q <= {link.scl, link.sda, addr_strap_pins, port_pin_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            prev_q <= filt_q;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= st_idle;
            shift_q <= 8'h00;
            count_q <= 4'h0;
            rw_q <= 1'b0;
            cmd_due_q <= 1'b0;
            sda_out_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
            ptr_q <= i2c_exp_pkg::POINTER_RESET;
            out_q <= WIDTH'(i2c_exp_pkg::OUTPUT_RESET);
            inv_q <= WIDTH'(i2c_exp_pkg::INVERT_RESET);
            dir_q <= WIDTH'(i2c_exp_pkg::DIRECTION_RESET);
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            count_q <= count_d;
            rw_q <= rw_d;
            cmd_due_q <= cmd_due_d;
            sda_out_q <= sda_out_d;
            sda_oe_n_q <= sda_oe_n_d;
            ptr_q <= ptr_d;
            out_q <= out_d;
            inv_q <= inv_d;
            dir_q <= dir_d;
        end
    end

    assign link.dev_sda_out = sda_out_q;
    assign link.dev_sda_oe_n = sda_oe_n_q;
    // Latch goes to every pin; the enable keeps it off input pins
    assign port_pin_out = out_q;
    assign port_pin_oe_n = dir_q;
endmodule

// ### src/i2c_exp_host.sv
// Bus master: runs start, stop and byte commands on the two-wire link
`timescale 1ns/1ns
module i2c_exp_host #(
    parameter int QUARTER = i2c_exp_pkg::QUARTER_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    i2c_link_if.host link,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack
);
    typedef enum logic [1:0] {
        hs_idle = 2'h0,
        hs_start = 2'h1,
        hs_byte = 2'h3,
        hs_stop = 2'h2
    } hstate_type;

    hstate_type state_q, state_d;
    logic [1:0] s1_q, s2_q, s3_q, filt_q;
    logic [7:0] div_q, div_d;
    logic [1:0] qtr_q, qtr_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] tx_q, tx_d, rx_q, rx_d;
    logic read_q, read_d, last_q, last_d, nack_q, nack_d;
    logic owned_q, owned_d;
    logic scl_rel_q, scl_rel_d, sda_rel_q, sda_rel_d;
    logic ready_q, ready_d, rsp_q, rsp_d;

    wire [1:0] agree = ~(s2_q ^ s3_q);
    wire [1:0] filt_d = (s2_q & agree) | (filt_q & ~agree);
    wire sda_in = filt_q[0];
    wire bus_free = filt_q[1] & filt_q[0];
    wire tick = div_q == 8'(QUARTER - 1);
    wire accept = ready_q && cmd_valid && state_q == hs_idle;
    // A start is refused until the bus is free or already ours
    wire start_ok = owned_q | bus_free;
    wire [2:0] tx_idx = 3'(4'h7 - bit_q);
    wire data_bit = (bit_q == i2c_exp_pkg::BITS_PER_BYTE) ? (read_q ? last_q : 1'b1) :
                    (read_q ? 1'b1 : tx_q[tx_idx]);
    wire done = tick && qtr_q == 2'h3 &&
                (state_q != hs_byte || bit_q == i2c_exp_pkg::BITS_PER_BYTE);

    always_comb begin
        state_d = state_q;
        div_d = (state_q == hs_idle || tick) ? 8'h00 : div_q + 8'h01;
        qtr_d = tick ? qtr_q + 2'h1 : qtr_q;
        bit_d = bit_q;
        tx_d = tx_q;
        rx_d = rx_q;
        read_d = read_q;
        last_d = last_q;
        nack_d = nack_q;
        owned_d = owned_q;
        scl_rel_d = scl_rel_q;
        sda_rel_d = sda_rel_q;
        ready_d = ready_q;
        rsp_d = 1'b0;
        if (accept) begin
            ready_d = 1'b0;
            qtr_d = 2'h0;
            bit_d = 4'h0;
            tx_d = cmd_data;
            read_d = cmd_op == i2c_exp_pkg::CMD_READ;
            last_d = cmd_last;
            unique case (cmd_op)
                i2c_exp_pkg::CMD_START: state_d = start_ok ? hs_start : hs_idle;
                i2c_exp_pkg::CMD_STOP: state_d = hs_stop;
                default: state_d = hs_byte;
            endcase
            if (cmd_op == i2c_exp_pkg::CMD_START && !start_ok) begin
                ready_d = 1'b1;
            end
        end else if (tick) begin
            unique case (state_q)
                hs_start: begin
                    unique case (qtr_q)
                        2'h0: sda_rel_d = 1'b1;
                        2'h1: scl_rel_d = 1'b1;
                        2'h2: sda_rel_d = 1'b0;
                        2'h3: scl_rel_d = 1'b0;
                    endcase
                end
                hs_stop: begin
                    unique case (qtr_q)
                        2'h0: sda_rel_d = 1'b0;
                        2'h1: scl_rel_d = 1'b1;
                        2'h2: sda_rel_d = 1'b1;
                        2'h3: ;
                    endcase
                end
                hs_byte: begin
                    unique case (qtr_q)
                        2'h0: sda_rel_d = data_bit;
                        2'h1: scl_rel_d = 1'b1;
                        2'h2: begin
                            if (bit_q == i2c_exp_pkg::BITS_PER_BYTE) begin
                                nack_d = sda_in;
                            end else begin
                                rx_d = {rx_q[6:0], sda_in};
                            end
                        end
                        2'h3: begin
                            scl_rel_d = 1'b0;
                            bit_d = bit_q + 4'h1;
                        end
                    endcase
                end
                default: ;
            endcase
        end
        if (done) begin
            state_d = hs_idle;
            ready_d = 1'b1;
            rsp_d = 1'b1;
            owned_d = state_q != hs_stop;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 2'h3;
            s2_q <= 2'h3;
            s3_q <= 2'h3;
            filt_q <= 2'h3;
        end else begin
            s1_q <= {link.scl, link.sda};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= hs_idle;
            div_q <= 8'h00;
            qtr_q <= 2'h0;
            bit_q <= 4'h0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            read_q <= 1'b0;
            last_q <= 1'b0;
            nack_q <= 1'b0;
            owned_q <= 1'b0;
            scl_rel_q <= 1'b1;
            sda_rel_q <= 1'b1;
            ready_q <= 1'b1;
            rsp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            div_q <= div_d;
            qtr_q <= qtr_d;
            bit_q <= bit_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            read_q <= read_d;
            last_q <= last_d;
            nack_q <= nack_d;
            owned_q <= owned_d;
            scl_rel_q <= scl_rel_d;
            sda_rel_q <= sda_rel_d;
            ready_q <= ready_d;
            rsp_q <= rsp_d;
        end
    end

    // Open drain: the out level equals the enable, so a one is a release
    assign link.host_scl_out = scl_rel_q;
    assign link.host_scl_oe_n = scl_rel_q;
    assign link.host_sda_out = sda_rel_q;
    assign link.host_sda_oe_n = sda_rel_q;
    assign cmd_ready = ready_q;
    assign rsp_valid = rsp_q;
    assign rsp_data = rx_q;
    assign rsp_nack = nack_q;
endmodule

// ### src/i2c_exp_pkg.sv
// Shared constants for the serial port expander and its bus master
package i2c_exp_pkg;
    localparam int PORT_WIDTH = 8;
    localparam int STRAP_WIDTH = 3;
    localparam logic [3:0] ADDR_FIXED = 4'h7;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam logic [1:0] REG_INPUT = 2'h0;
    localparam logic [1:0] REG_OUTPUT = 2'h1;
    localparam logic [1:0] REG_INVERT = 2'h2;
    localparam logic [1:0] REG_DIRECTION = 2'h3;
    localparam int SEL_HI = 1;
    localparam int SEL_LO = 0;
    localparam logic [7:0] OUTPUT_RESET = 8'hff;
    localparam logic [7:0] INVERT_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hff;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 160;
    localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLOCK_PERIOD_NS);
    localparam logic [1:0] CMD_START = 2'h0;
    localparam logic [1:0] CMD_STOP = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;
endpackage

// ### src/i2c_link_if.sv
// Two-wire open-drain link between the bus master and the expander
`timescale 1ns/1ns
interface i2c_link_if;
    logic host_scl_out;
    logic host_scl_oe_n;
    logic host_sda_out;
    logic host_sda_oe_n;
    logic dev_sda_out;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;
    // Wired-and of every enabled driver; pull-ups give the high level
    assign scl = host_scl_oe_n | host_scl_out;
    assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);
    modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe_n);
    modport host (input scl, input sda, output host_scl_out, output host_scl_oe_n,
                  output host_sda_out, output host_sda_oe_n);
endinterface

// ### tb/i2c_exp_props.sv
// Link checker for the expander and its bus master
`timescale 1ns/1ns
module i2c_exp_props (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe_n,
    input wire logic [i2c_exp_pkg::STRAP_WIDTH-1:0] addr_strap_pins
);
    logic scl_q, sda_q, busy_q, match_q, read_q, nacked_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] shift_q;
    wire rise = scl & ~scl_q;
    wire start_seen = scl & scl_q & sda_q & ~sda;
    wire stop_seen = scl & scl_q & ~sda_q & sda;
    wire ack_rise = rise & busy_q & (bit_q == 4'h8);
    wire addr_hit = shift_q[7:1] == {i2c_exp_pkg::ADDR_FIXED, addr_strap_pins};
    wire addr_ack = ack_rise & (byte_q == 2'h0);
    wire data_ack = ack_rise & (byte_q != 2'h0) & match_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            busy_q <= 1'b0;
            match_q <= 1'b0;
            read_q <= 1'b0;
            nacked_q <= 1'b0;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            shift_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_seen) begin
                busy_q <= 1'b1;
                bit_q <= 4'h0;
                byte_q <= 2'h0;
                nacked_q <= 1'b0;
            end else if (stop_seen) begin
                busy_q <= 1'b0;
            end else if (rise && bit_q == 4'h8) begin
                bit_q <= 4'h0;
                byte_q <= (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
                match_q <= (byte_q == 2'h0) ? addr_hit : match_q;
                read_q <= (byte_q == 2'h0) ? shift_q[0] : read_q;
                nacked_q <= nacked_q | (data_ack & read_q & sda);
            end else if (rise) begin
                bit_q <= bit_q + 4'h1;
                shift_q <= (byte_q == 2'h0) ? {shift_q[6:0], sda} : shift_q;
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Scl high phase lasts eight cycles at the default quarter
    sequence s_held_low;
        (!dev_sda_oe_n) [*8];
    endsequence
    sequence s_held_free;
        dev_sda_oe_n [*8];
    endsequence
    property p_addr_ack;
        addr_ack && addr_hit |-> s_held_low;
    endproperty
    property p_addr_miss;
        addr_ack && !addr_hit |-> s_held_free;
    endproperty
    property p_wr_ack;
        data_ack && !read_q |-> (!dev_sda_oe_n) throughout (scl [*7]);
    endproperty
    property p_rd_free;
        data_ack && read_q |-> s_held_free;
    endproperty
    property p_nack_free;
        nacked_q && busy_q |-> dev_sda_oe_n;
    endproperty
    property p_idle_free;
        !busy_q |-> dev_sda_oe_n;
    endproperty
    property p_addr_quiet;
        busy_q && byte_q == 2'h0 && bit_q < 4'h8 |-> dev_sda_oe_n;
    endproperty
    property p_stable_high;
        scl && $past(scl) |-> $stable(dev_sda_oe_n);
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address not acknowledged");
    a_addr_miss: assert property (p_addr_miss)
        else $error("foreign address acknowledged");
    a_wr_ack: assert property (p_wr_ack)
        else $error("written byte not acknowledged");
    a_rd_free: assert property (p_rd_free)
        else $error("data line held in read ack slot");
    a_nack_free: assert property (p_nack_free)
        else $error("data line driven after nack");
    a_idle_free: assert property (p_idle_free)
        else $error("data line driven on idle bus");
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("data line driven during address");
    a_stable_high: assert property (p_stable_high)
        else $error("data line changed while clock high");
endmodule

// ### tb/i2c_gpio_expander_core_tb.sv
// Bench joining the bus master and the expander over one link
`timescale 1ns/1ns
module i2c_gpio_expander_core_tb;
    logic clock, resetn, cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_nack;
    logic [1:0] cmd_op;
    logic [7:0] cmd_data, rsp_data, port_pin_in, port_pin_out, port_pin_oe_n, ext_level;
    logic [2:0] strap;
    int errors, cmp_count;
    i2c_link_if link ();
    i2c_exp_host u_i2c_exp_host (.clock(clock), .resetn(resetn), .link(link.host),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_last(cmd_last),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
    i2c_exp_device u_i2c_exp_device (.clock(clock), .resetn(resetn), .link(link.device),
        .addr_strap_pins(strap), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
        .port_pin_oe_n(port_pin_oe_n));
    i2c_exp_props u_i2c_exp_props (.clock(clock), .resetn(resetn), .scl(link.scl),
        .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n), .addr_strap_pins(strap));
    // Pin level: driven bits follow the latch, released bits the outside world
    assign port_pin_in = (port_pin_oe_n & ext_level) | (~port_pin_oe_n & port_pin_out);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Polls cmd_ready, or rsp_valid when rsp is set; bounded so a hang fails
    task automatic wait_high(input bit rsp);
        int n;
        n = 0;
        while ((rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 400) begin
                errors++;
                close_out();
            end
        end
    endtask
    // Entered one step after a clock edge
    task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic l);
        wait_high(1'b0);
        cmd_op = op;
        cmd_data = d;
        cmd_last = l;
        cmd_valid = 1'b1;
        @(posedge clock);
        #1 cmd_valid = 1'b0;
        @(posedge clock);
        #1;
        wait_high(1'b1);
    endtask
    task automatic wbyte(input logic [7:0] d, input logic nack);
        cmd(i2c_exp_pkg::CMD_WRITE, d, 1'b0);
        check({7'h00, rsp_nack}, {7'h00, nack});
    endtask
    task automatic open_xfer(input logic rw, input logic [2:0] s, input logic nack);
        cmd(i2c_exp_pkg::CMD_START, 8'h00, 1'b0);
        wbyte({i2c_exp_pkg::ADDR_FIXED, s, rw}, nack);
    endtask
    task automatic wr_reg(input logic [1:0] ptr, input logic [7:0] d);
        open_xfer(i2c_exp_pkg::RW_WRITE, strap, 1'b0);
        wbyte({6'h00, ptr}, 1'b0);
        wbyte(d, 1'b0);
        cmd(i2c_exp_pkg::CMD_STOP, 8'h00, 1'b0);
    endtask
    task automatic rd_reg(input logic [1:0] ptr, input logic [7:0] exp);
        open_xfer(i2c_exp_pkg::RW_WRITE, strap, 1'b0);
        wbyte({6'h00, ptr}, 1'b0);
        open_xfer(i2c_exp_pkg::RW_READ, strap, 1'b0);
        cmd(i2c_exp_pkg::CMD_READ, 8'h00, 1'b1);
        check(rsp_data, exp);
        cmd(i2c_exp_pkg::CMD_STOP, 8'h00, 1'b0);
    endtask
    task automatic check_defaults;
        check(port_pin_out, i2c_exp_pkg::OUTPUT_RESET);
        check(port_pin_oe_n, i2c_exp_pkg::DIRECTION_RESET);
        rd_reg(i2c_exp_pkg::REG_OUTPUT, i2c_exp_pkg::OUTPUT_RESET);
        rd_reg(i2c_exp_pkg::REG_INVERT, i2c_exp_pkg::INVERT_RESET);
        rd_reg(i2c_exp_pkg::REG_DIRECTION, i2c_exp_pkg::DIRECTION_RESET);
        rd_reg(i2c_exp_pkg::REG_INPUT, ext_level);
        $display("test defaults done");
    endtask
    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_data = 8'h00;
        cmd_last = 1'b0;
        ext_level = 8'hc3;
        strap = 3'h5;
        errors = 0;
        cmp_count = 0;
        repeat (16) @(posedge clock);
        #1 resetn = 1'b1;
        repeat (8) @(posedge clock);
        #1;
        check_defaults();
        // Straps only change between transfers, then settle through the filter
        for (int s = 0; s < 8; s++) begin
            strap = s[2:0];
            repeat (8) @(posedge clock);
            #1;
            open_xfer(i2c_exp_pkg::RW_WRITE, s[2:0], 1'b0);
            open_xfer(i2c_exp_pkg::RW_WRITE, s[2:0] ^ 3'h2, 1'b1);
            cmd(i2c_exp_pkg::CMD_STOP, 8'h00, 1'b0);
        end
        strap = 3'h5;
        repeat (8) @(posedge clock);
        #1;
        $display("test addresses done");
        wr_reg(i2c_exp_pkg::REG_OUTPUT, 8'h5a);
        wr_reg(i2c_exp_pkg::REG_DIRECTION, 8'h0f);
        check(port_pin_out, 8'h5a);
        check(port_pin_oe_n, 8'h0f);
        rd_reg(i2c_exp_pkg::REG_INPUT, 8'h53);
        rd_reg(i2c_exp_pkg::REG_OUTPUT, 8'h5a);
        wr_reg(i2c_exp_pkg::REG_INVERT, 8'hff);
        rd_reg(i2c_exp_pkg::REG_INPUT, 8'hac);
        wr_reg(i2c_exp_pkg::REG_INPUT, 8'h00);
        rd_reg(i2c_exp_pkg::REG_INPUT, 8'hac);
        rd_reg(i2c_exp_pkg::REG_INVERT, 8'hff);
        $display("test port registers done");
        open_xfer(i2c_exp_pkg::RW_WRITE, strap, 1'b0);
        wbyte({6'h00, i2c_exp_pkg::REG_OUTPUT}, 1'b0);
        for (int i = 1; i < 4; i++) begin
            wbyte(8'h11 * i[7:0], 1'b0);
            check(port_pin_out, 8'h11 * i[7:0]);
        end
        cmd(i2c_exp_pkg::CMD_STOP, 8'h00, 1'b0);
        check(port_pin_oe_n, 8'h0f);
        $display("test burst write done");
        open_xfer(i2c_exp_pkg::RW_READ, strap, 1'b0);
        for (int i = 0; i < 3; i++) begin
            cmd(i2c_exp_pkg::CMD_READ, 8'h00, i == 2);
            check(rsp_data, 8'h33);
        end
        cmd(i2c_exp_pkg::CMD_STOP, 8'h00, 1'b0);
        $display("test burst read done");
        open_xfer(i2c_exp_pkg::RW_WRITE, strap, 1'b0);
        wbyte(8'h03, 1'b0);
        resetn = 1'b0;
        repeat (16) @(posedge clock);
        #1 resetn = 1'b1;
        repeat (8) @(posedge clock);
        #1;
        check_defaults();
        close_out();
    end
endmodule
